// File: dual_address_i2c_memory_slave.sv
// two-wire slave with main and auxiliary memories
//
// Notes on behaviour
// RL1: sda falling while scl high is start; sda rising is stop.
// RL2: a repeated start is handled exactly like a start.
// RL3: data changes while scl low; device samples on scl rising edge.
// RL4: read bits are driven at the falling edge before their clock.
// RL5: ninth bit is acknowledge, low ack, high nack, same timing.
// RL6: master bytes are eight bits msb first, then device ack.
// RL7: master nacks last read byte; device then releases sda.
// RL8: first byte holds seven-bit address and direction, 1 means read.
// RL9: auxiliary memory answers at fixed address A0h.
// RL10: main memory answers at programmable address byte, 00h to FEh.
// RL11: programmable main address works only with address select set.
// RL12: unmatched address means ignore the bus until next start.
// RL13: main address programmed to A0h disables the auxiliary memory.
// RL14: second write byte is the memory address, loaded into counter.
// RL15: one to eight data bytes stored at consecutive addresses.
// RL16: write counter wraps inside its eight-byte row.
// RL17: master must stop and wait before writing the next row.
// RL18: no address ack until page programming time has passed.
// RL19: a write programs the whole page, unwritten bytes keep values.
// RL20: shadowed writes with shadow enable set start no programming.
// RL21: reads start at the current address counter, no address byte.
// RL22: random read uses dummy write then repeated start and read.
// RL23: before supply threshold the main address defaults to A2h.
// RL24: shadowed writes finish at once so address acks right after.
// RL25: counter increments after each read byte.
`timescale 1ns/1ps
module dual_address_i2c_memory_slave
  import i2c_slave_pkg::*;
(
  // system
  input  wire logic clk,
  input  wire logic rst,
  // two-wire bus, open drain
  input  wire logic scl,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  // supply monitor, high above power-on threshold
  input  wire logic vccAboveThreshold,
  // page programming in progress
  output logic      progBusy
);

  ////////////////////////////////////////////////////////////////////////
  // pin sampling and bus events

  logic [2:0] pinLevels;
  logic       sclS;
  logic       sdaS;
  logic       pwrS;
  logic       sclD;
  logic       sdaD;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;

  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .pinIn   ({vccAboveThreshold, sdaIn, scl}),
    .pinSync (pinLevels)
  );

  assign sclS = pinLevels[0];
  assign sdaS = pinLevels[1];
  assign pwrS = pinLevels[2];

  // previous synchronised levels for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  // a repeated start is the same event as a start
  assign sclRise   = sclS & ~sclD; // RL3
  assign sclFall   = ~sclS & sclD;
  assign startSeen = sclS & sclD & sdaD & ~sdaS; // RL1 RL2
  assign stopSeen  = sclS & sclD & ~sdaD & sdaS; // RL1

  ////////////////////////////////////////////////////////////////////////
  // storage and configuration

  logic [7:0] mainMem [256];
  logic [7:0] auxMem  [256];
  logic [7:0] shadowCfg;
  logic [7:0] aselCfg;
  logic [7:0] mainAddrReg;

  // read view: configuration bytes live in flops, not the array
  function automatic logic [7:0] readByte(input logic       aux,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = aux ? auxMem[a] : mainMem[a];
    if (!aux) begin
      if (a == SHADOW_CFG_OFF) v = shadowCfg;
      if (a == ADDRESS_SELECT_BIT_CFG_OFF)   v = aselCfg;
      if (a == MAIN_ADDR_OFF)  v = mainAddrReg;
    end
    return v;
  endfunction : readByte

  // shadowed rows bypass the programming delay
  function automatic logic isShadowed(input logic       aux,
                                      input logic [4:0] row);
    return !aux && ({row, 3'b000} >= SHADOW_FIRST);
  endfunction : isShadowed

  ////////////////////////////////////////////////////////////////////////
  // slave address decode

  logic       mainActive;
  logic [7:0] mainAddrEff;
  logic       auxBlocked;
  logic       hitMain;
  logic       hitAux;
  logic [7:0] shiftReg;

  // stored address is not trusted until supply passes the threshold;
  // the default must answer then, even with address select clear
  assign mainAddrEff = pwrS ? mainAddrReg : POA_DEFAULT_ADDR; // RL23
  assign mainActive  = aselCfg[ADDRESS_SELECT_BIT_POS] | ~pwrS; // RL11
  assign auxBlocked  = mainActive &&
                       mainAddrEff[7:1] == AUX_SLAVE_ADDR[7:1]; // RL13
  assign hitMain     = mainActive && !progBusy &&
                       shiftReg[7:1] == mainAddrEff[7:1]; // RL10 RL18
  assign hitAux      = !auxBlocked && !progBusy &&
                       shiftReg[7:1] == AUX_SLAVE_ADDR[7:1]; // RL9 RL18

  ////////////////////////////////////////////////////////////////////////
  // transfer state machine

  state_t     state;
  kind_t      kind;
  logic [3:0] bitCnt;
  logic       readMode;
  logic       auxSel;
  logic       masterAck;
  logic [7:0] addrCnt;
  logic [7:0] rdData;
  logic       byteDone;
  logic       dataTake;
  logic [7:0] nextRowAddr;

  assign rdData   = readByte(auxSel, addrCnt); // RL21
  assign byteDone = state == ST_RECV && sclFall && bitCnt == BYTE_BITS &&
                    !startSeen && !stopSeen;
  assign dataTake = byteDone && kind == KIND_DATA;
  // increments stay inside the current row
  assign nextRowAddr = {addrCnt[7:ROW_BITS],
                        addrCnt[ROW_BITS-1:0] + 3'b001}; // RL16

  // bit engine; sdaOe high pulls sda low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      kind      <= KIND_DEV;
      bitCnt    <= 4'h0;
      shiftReg  <= 8'h00;
      readMode  <= 1'b0;
      auxSel    <= 1'b0;
      masterAck <= 1'b0;
      addrCnt   <= 8'h00;
      sdaOe     <= 1'b0;
    end else if (startSeen) begin
      state  <= ST_RECV; // RL2
      kind   <= KIND_DEV; // RL8
      bitCnt <= 4'h0;
      sdaOe  <= 1'b0;
    end else if (stopSeen) begin
      state <= ST_IDLE;
      sdaOe <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          sdaOe <= 1'b0; // RL12
        end
        ST_RECV: begin
          if (sclRise && bitCnt != BYTE_BITS) begin
            shiftReg <= {shiftReg[6:0], sdaS}; // RL6
            bitCnt   <= bitCnt + 4'h1;
          end else if (byteDone) begin
            unique case (kind)
              KIND_DEV: begin
                if (hitMain || hitAux) begin
                  auxSel   <= hitAux && !hitMain;
                  readMode <= shiftReg[0]; // RL8
                  sdaOe    <= 1'b1; // RL5
                  state    <= ST_ACK;
                end else begin
                  state <= ST_IDLE; // RL12
                end
              end
              KIND_MEM: begin
                addrCnt <= shiftReg; // RL14
                sdaOe   <= 1'b1;
                state   <= ST_ACK;
              end
              default: begin
                addrCnt <= nextRowAddr; // RL15 RL16
                sdaOe   <= 1'b1;
                state   <= ST_ACK;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            bitCnt <= 4'h0;
            if (readMode) begin
              shiftReg <= rdData; // RL21
              sdaOe    <= ~rdData[7]; // RL4
              state    <= ST_SEND;
            end else begin
              sdaOe <= 1'b0;
              state <= ST_RECV;
              kind  <= (kind == KIND_DEV) ? KIND_MEM : KIND_DATA; // RL14
            end
          end
        end
        ST_SEND: begin
          if (sclRise) begin
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall) begin
            if (bitCnt == BYTE_BITS) begin
              sdaOe     <= 1'b0; // RL7
              masterAck <= 1'b0;
              addrCnt   <= addrCnt + 8'h01; // RL25
              state     <= ST_MACK;
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              sdaOe    <= ~shiftReg[6]; // RL4 RL6
            end
          end
        end
        ST_MACK: begin
          if (sclRise) begin
            masterAck <= ~sdaS; // RL5
          end else if (sclFall) begin
            if (masterAck) begin
              shiftReg <= rdData;
              sdaOe    <= ~rdData[7]; // RL4
              bitCnt   <= 4'h0;
              state    <= ST_SEND;
            end else begin
              state <= ST_IDLE; // RL7
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // open-drain: the data level is always low, only the enable moves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page buffer

  logic [7:0]            pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageMask;
  logic [4:0]            pageRow;
  logic                  pageAux;
  logic                  commit;

  // a start also ends the write, so a repeated start cannot lose it
  assign commit = (startSeen || stopSeen) && (pageMask != '0);

  // collect written bytes; a new byte in the commit cycle cannot occur
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageMask <= '0;
      pageRow  <= 5'h00;
      pageAux  <= 1'b0;
    end else if (commit) begin
      pageMask <= '0;
    end else if (dataTake) begin
      pageMask[addrCnt[ROW_BITS-1:0]] <= 1'b1; // RL19
      pageRow <= addrCnt[7:ROW_BITS];
      pageAux <= auxSel;
    end
  end

  // byte contents need no reset, the mask qualifies them
  always_ff @(posedge clk) begin
    if (dataTake) begin
      pageBuf[addrCnt[ROW_BITS-1:0]] <= shiftReg; // RL15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page commit into memory and configuration

  // only bytes marked in the mask change; the rest of the page stays
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pageMask[i]) begin
          if (pageAux) begin
            auxMem[{pageRow, 3'(i)}] <= pageBuf[i]; // RL19
          end else begin
            mainMem[{pageRow, 3'(i)}] <= pageBuf[i]; // RL19
          end
        end
      end
    end
  end

  // configuration flops mirror their addresses in main memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadowCfg   <= CFG_RST;
      aselCfg     <= CFG_RST;
      mainAddrReg <= MAIN_ADDR_RST;
    end else if (commit && !pageAux) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pageMask[i]) begin
          if ({pageRow, 3'(i)} == SHADOW_CFG_OFF) shadowCfg <= pageBuf[i];
          if ({pageRow, 3'(i)} == ADDRESS_SELECT_BIT_CFG_OFF)   aselCfg   <= pageBuf[i];
          if ({pageRow, 3'(i)} == MAIN_ADDR_OFF) begin
            mainAddrReg <= pageBuf[i]; // RL10
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // programming busy timer

  logic [11:0] busyCnt;

  // shadowed rows with shadow enable skip the wait entirely
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt  <= 12'h000;
      progBusy <= 1'b0;
    end else if (commit &&
                 !(shadowCfg[SHADOW_EN_POS] &&
                   isShadowed(pageAux, pageRow))) begin // RL20 RL24
      busyCnt  <= PROG_CYCLES - 12'h001; // RL18
      progBusy <= 1'b1;
    end else if (busyCnt != 12'h000) begin
      busyCnt <= busyCnt - 12'h001;
    end else begin
      progBusy <= 1'b0;
    end
  end

endmodule : dual_address_i2c_memory_slave

// File: i2c_slave_pkg.sv
// constants and types shared by the two-wire memory slave
package i2c_slave_pkg;

  // slave addresses
  localparam logic [7:0] AUX_SLAVE_ADDR   = 8'hA0;
  localparam logic [7:0] POA_DEFAULT_ADDR = 8'hA2;

  // configuration bytes in the main memory
  localparam logic [7:0] SHADOW_CFG_OFF   = 8'h80;
  localparam logic [7:0] ADDRESS_SELECT_BIT_CFG_OFF     = 8'h89;
  localparam logic [7:0] MAIN_ADDR_OFF    = 8'h8C;
  localparam int         SHADOW_EN_POS    = 0;
  localparam int         ADDRESS_SELECT_BIT_POS         = 0;
  localparam logic [7:0] CFG_RST          = 8'h00;
  localparam logic [7:0] MAIN_ADDR_RST    = 8'hA2;

  // main memory at and above this address is shadowed
  localparam logic [7:0] SHADOW_FIRST     = 8'h80;

  // framing
  localparam logic [3:0] BYTE_BITS        = 4'h8;
  localparam int         PAGE_BYTES       = 8;
  localparam int         ROW_BITS         = 3;

  // page programming time, least time so rounded up
  localparam int         CLK_PERIOD_PS    = 4000;
  localparam int         PROG_TIME_US     = 10;
  localparam int         PROG_CYCLES_INT  =
    (PROG_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] PROG_CYCLES     = 12'(PROG_CYCLES_INT);

  // transfer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RECV = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_SEND = 5'b01000,
    ST_MACK = 5'b10000
  } state_t;

  // meaning of the byte being received
  typedef enum logic [2:0] {
    KIND_DEV  = 3'b001,
    KIND_MEM  = 3'b010,
    KIND_DATA = 3'b100
  } kind_t;

endpackage : i2c_slave_pkg

// File: pin_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  // system
  input  wire logic             clk,
  input  wire logic             rst,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second; reset to the pins' idle high
  // level, else a false edge follows every reset
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        stage1[i]  <= 1'b1;
        pinSync[i] <= 1'b1;
      end else begin
        stage1[i]  <= pinIn[i];
        pinSync[i] <= stage1[i];
      end
    end
  end

endmodule : pin_sync

// File: dual_address_i2c_memory_slave_checker.sv
// port assertions for the two-wire memory slave
`timescale 1ns/1ps
module dual_address_i2c_memory_slave_checker
  import i2c_slave_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst,
  // bus and status
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic vccAboveThreshold,
  input wire logic progBusy
);
  logic [11:0] busyCount;

  // cycles spent busy so far, cleared between periods
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      busyCount <= 12'h000;
    else if (progBusy)
      busyCount <= busyCount + 12'h001;
    else
      busyCount <= 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_idle_a: assert property ($past(rst) |-> !sdaOe && !progBusy)
    else $error("bus not idle after reset");
  bit_change_a: assert property ($changed(sdaOe) |-> !scl)
    else $error("sda drive changed while scl high");
  ack_hold_a: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("low bit not held");
  release_hold_a: assert property ($fell(sdaOe) |-> !sdaOe [*8])
    else $error("released sda grabbed too soon");
  open_drain_a: assert property (sdaOe |-> sdaOut == 1'b0)
    else $error("sda driven high");
  busy_length_a: assert property ($fell(progBusy) |->
    busyCount == PROG_CYCLES)
    else $error("programming time wrong");
  busy_bound_a: assert property (busyCount <= PROG_CYCLES)
    else $error("programming runs too long");
  busy_no_ack_a: assert property (progBusy |-> !sdaOe)
    else $error("device answered while busy");
  commit_on_stop_a: assert property ($rose(progBusy) |->
    scl && $past(scl, 2))
    else $error("programming began outside a stop");
endmodule : dual_address_i2c_memory_slave_checker

bind dual_address_i2c_memory_slave dual_address_i2c_memory_slave_checker
  u_checker (.clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .vccAboveThreshold(vccAboveThreshold),
  .progBusy(progBusy));

// File: i2c_master_model.sv
// bus master model driving the two-wire bus
`timescale 1ns/1ps
module i2c_master_model (
  // system
  input  wire logic clk,
  // bus: clock out, data pull-down enable, wire level in
  output logic      scl,
  output logic      masterOe,
  input  wire logic sda
);
  // idle bus: clock parked high, data left to the pull-up
  initial begin
    scl = 1'b1;
    masterOe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // data moves mid low phase, never beside a clock edge
  task automatic bitCycle(input logic b, output logic s);
    tick(4);
    masterOe <= !b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    s = sda;
    scl <= 1'b0;
  endtask : bitCycle

  // also serves as repeated start from a low clock
  task automatic start();
    tick(4);
    masterOe <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    masterOe <= 1'b1;
    tick(8);
    scl <= 1'b0;
  endtask : start

  // ends the frame; clock then stands high
  task automatic stop();
    tick(4);
    masterOe <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    masterOe <= 1'b0;
    tick(8);
  endtask : stop

  // msb first, then the device's acknowledge bit
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitCycle(d[i], s);
    bitCycle(1'b1, s);
    ack = !s;
  endtask : sendByte

  // last byte is refused so the device lets go of sda
  task automatic recvByte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitCycle(1'b1, d[i]);
    bitCycle(last, s);
  endtask : recvByte
endmodule : i2c_master_model

// File: dual_address_i2c_memory_slave_tb.sv
// testbench for the two-wire memory slave
`timescale 1ns/1ps
module dual_address_i2c_memory_slave_tb;
  import i2c_slave_pkg::*;
  logic clk;
  logic rst;
  logic scl;
  logic sda;
  logic sdaOut;
  logic sdaOe;
  logic masterOe;
  logic vccAboveThreshold;
  logic progBusy;
  int   mismatches = 0;
  int   checked = 0;
  int   cycles = 0;

  // open-drain wire with pull-up
  assign sda = !((sdaOe && !sdaOut) || masterOe);

  dual_address_i2c_memory_slave u_dual_address_i2c_memory_slave (
    .clk(clk), .rst(rst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .vccAboveThreshold(vccAboveThreshold),
    .progBusy(progBusy));
  i2c_master_model u_i2c_master_model (
    .clk(clk), .scl(scl), .masterOe(masterOe), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // address plus one byte; an ignored address leaves both unanswered
  task automatic probe(input logic [7:0] dev, input logic exp);
    logic a1;
    logic a2;
    u_i2c_master_model.start();
    u_i2c_master_model.sendByte(dev, a1);
    u_i2c_master_model.sendByte(8'h00, a2);
    u_i2c_master_model.stop();
    check(8'({a1, a2}), {6'h00, exp, exp});
  endtask : probe

  task automatic wr(input logic [7:0] dev, mem, input logic [7:0] d [$]);
    logic a;
    u_i2c_master_model.start();
    u_i2c_master_model.sendByte(dev, a);
    check(8'(a), 8'h01);
    u_i2c_master_model.sendByte(mem, a);
    check(8'(a), 8'h01);
    foreach (d[i]) begin
      u_i2c_master_model.sendByte(d[i], a);
      check(8'(a), 8'h01);
    end
    u_i2c_master_model.stop();
  endtask : wr

  // current-address read, opened by a (repeated) start
  task automatic rdCur(input logic [7:0] dev, input logic [7:0] e [$]);
    logic a;
    logic [7:0] v;
    u_i2c_master_model.start();
    u_i2c_master_model.sendByte(dev | 8'h01, a);
    check(8'(a), 8'h01);
    foreach (e[i]) begin
      u_i2c_master_model.recvByte(i == e.size() - 1, v);
      check(v, e[i]);
    end
    u_i2c_master_model.stop();
  endtask : rdCur

  // dummy write sets the counter, then repeated start
  task automatic rdAt(input logic [7:0] dev, mem, input logic [7:0] e [$]);
    logic a;
    u_i2c_master_model.start();
    u_i2c_master_model.sendByte(dev, a);
    u_i2c_master_model.sendByte(mem, a);
    rdCur(dev, e);
  endtask : rdAt

  // busy must show, refuse the address, then end
  task automatic waitBusy(input logic [7:0] dev);
    int n;
    n = 0;
    while (progBusy !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(8'(progBusy), 8'h01);
    probe(dev, 1'b0);
    while (progBusy === 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(8'(progBusy), 8'h00);
  endtask : waitBusy

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    vccAboveThreshold = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    probe(POA_DEFAULT_ADDR, 1'b0);
    vccAboveThreshold <= 1'b0;
    probe(POA_DEFAULT_ADDR, 1'b1);
    wr(POA_DEFAULT_ADDR, ADDRESS_SELECT_BIT_CFG_OFF, '{8'h01, 8'h00, 8'h00, 8'h50});
    waitBusy(POA_DEFAULT_ADDR);
    vccAboveThreshold <= 1'b1;
    probe(8'h50, 1'b1);
    probe(POA_DEFAULT_ADDR, 1'b0);
    probe(AUX_SLAVE_ADDR, 1'b1);
    rdAt(8'h50, MAIN_ADDR_OFF, '{8'h50});
    wr(AUX_SLAVE_ADDR, 8'h00, '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84,
      8'h85, 8'h86, 8'h87});
    waitBusy(AUX_SLAVE_ADDR);
    wr(AUX_SLAVE_ADDR, 8'h06, '{8'h11, 8'h22, 8'h33});
    waitBusy(AUX_SLAVE_ADDR);
    rdAt(AUX_SLAVE_ADDR, 8'h00, '{8'h33, 8'h81, 8'h82, 8'h83, 8'h84,
      8'h85, 8'h11, 8'h22});
    rdAt(AUX_SLAVE_ADDR, 8'h02, '{8'h82});
    rdCur(AUX_SLAVE_ADDR, '{8'h83});
    wr(8'h50, SHADOW_CFG_OFF, '{8'h01});
    waitBusy(8'h50);
    wr(8'h50, MAIN_ADDR_OFF, '{AUX_SLAVE_ADDR});
    check(8'(progBusy), 8'h00);
    rdAt(AUX_SLAVE_ADDR, MAIN_ADDR_OFF, '{AUX_SLAVE_ADDR});
    finish_test();
  end
endmodule : dual_address_i2c_memory_slave_tb
